// file: rtl/art_defines.vh
// Constants for the auto-reload timer core: register map, fields, encodings
`ifndef ART_DEFINES_VH
`define ART_DEFINES_VH

// Register byte offsets on the APB word map
`define ART_ADDR_CTRL1     8'h00
`define ART_ADDR_CTRL2     8'h04
`define ART_ADDR_PULSE     8'h08
`define ART_ADDR_STATUS    8'h0C
`define ART_ADDR_INTEN     8'h10
`define ART_ADDR_PRESET_HI 8'h14
`define ART_ADDR_PRESET_LO 8'h18
`define ART_ADDR_CMP_HI    8'h1C
`define ART_ADDR_CMP_LO    8'h20
`define ART_ADDR_MASK_HI   8'h24
`define ART_ADDR_MASK_LO   8'h28
`define ART_ADDR_CAPT_HI   8'h2C
`define ART_ADDR_CAPT_LO   8'h30
`define ART_ADDR_COUNT_HI  8'h34
`define ART_ADDR_COUNT_LO  8'h38

// CTRL1 fields
`define ART_C1_PSC_HI      7
`define ART_C1_PSC_LO      6
`define ART_C1_RELOAD      5
`define ART_C1_RUN         4
`define ART_C1_WRAP_FLAG   2
`define ART_C1_WRAP_MODE   1
// CTRL2 fields
`define ART_C2_A_POL       2
`define ART_C2_SEL_HI      1
`define ART_C2_SEL_LO      0
`define ART_C2_B_POL       3
// PULSE fields
`define ART_P_ENABLE       0
`define ART_P_MODE         1
`define ART_P_POL          2
// STATUS / INTEN bit positions
`define ART_S_A_FLAG       0
`define ART_S_A_ERR        1
`define ART_S_B_FLAG       2
`define ART_S_B_ERR        3
`define ART_S_CMP          4
`define ART_S_ZERO         5
`define ART_I_A            0
`define ART_I_B            1
`define ART_I_WRAP         2
`define ART_I_CMP          3
`define ART_I_ZERO         4

// Start source encodings {hi,lo}
`define ART_SRC_SW         2'b00
`define ART_SRC_EVT_A      2'b01
`define ART_SRC_EVT_B      2'b10
// Prescale encodings
`define ART_PSC_OFF        2'b00
`define ART_PSC_DIV1       2'b01
`define ART_PSC_DIV4       2'b10
`define ART_PSC_DIV16      2'b11
`define ART_DIV1_LAST      4'h0
`define ART_DIV4_LAST      4'h3
`define ART_DIV16_LAST     4'hF

// Values
`define ART_CNT_ZERO       16'h0000
`define ART_CNT_FULL       16'hFFFF
`define ART_BYTE_ZERO      8'h00

`endif

// file: rtl/art_prescaler.v
// Prescaler that turns the internal clock into counter ticks
`timescale 1ns/1ps
`default_nettype none
`include "art_defines.vh"

module art_prescaler (
  input  wire       ref_clk_in,   // Internal clock
  input  wire       rst_in,       // Sync reset, active high
  input  wire       ce_in,        // Clock enable
  input  wire       run_in,       // Low holds prescaler cleared
  input  wire [1:0] sel_in,       // Prescale select
  output reg        tick_out      // One-cycle counter tick
);

  reg  [3:0] div_cnt_ff;
  reg  [3:0] last_val;

  // Terminal count per ratio
  always @*
  begin
    case (sel_in)
      `ART_PSC_DIV1:  last_val = `ART_DIV1_LAST;
      `ART_PSC_DIV4:  last_val = `ART_DIV4_LAST;
      `ART_PSC_DIV16: last_val = `ART_DIV16_LAST;
      default:        last_val = `ART_DIV1_LAST;
    endcase
  end

  // Divider; select 00 stops both prescaler and counter
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      div_cnt_ff <= 4'h0;
      tick_out   <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!run_in || sel_in == `ART_PSC_OFF)
      begin
        div_cnt_ff <= 4'h0;
        tick_out   <= 1'b0;
      end
      else if (div_cnt_ff >= last_val)
      begin
        div_cnt_ff <= 4'h0;
        tick_out   <= 1'b1;
      end
      else
      begin
        div_cnt_ff <= div_cnt_ff + 4'h1;
        tick_out   <= 1'b0;
      end
    end
  end

endmodule // art_prescaler
`default_nettype wire

// file: rtl/art_timer_core.v
// 16-bit auto-reload timer core with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "art_defines.vh"

module art_timer_core (
  input  wire        ref_clk_in,     // 25 MHz clock
  input  wire        rst_in,         // Sync reset, active high
  input  wire        ce_in,          // Clock enable, low freezes state
  input  wire        psel_in,        // APB select
  input  wire        penable_in,     // APB enable
  input  wire        pwrite_in,      // APB write
  input  wire [7:0]  paddr_in,       // APB byte address
  input  wire [31:0] pwdata_in,      // APB write data
  output reg  [31:0] prdata_out,     // APB read data
  output reg         pready_out,     // APB ready
  output reg         pslverr_out,    // APB error on unmapped address
  input  wire        event_in_a,     // External event a
  input  wire        event_in_b,     // External event b
  output reg         pulse_out_pin,  // Pulse output pin
  output reg         wrap_out_pin,   // Wrap output pin
  output reg         irq_out         // Timer interrupt
);

  // Control and data registers
  reg  [7:0]  ctrl1_ff;
  reg  [7:0]  ctrl2_ff;
  reg  [7:0]  pulse_ff;
  reg  [4:0]  inten_ff;
  reg  [7:0]  stage_ff;
  reg  [15:0] preset_capture_reg;
  reg  [15:0] compare_reg;
  reg  [15:0] mask_ff;
  reg  [15:0] capture_reg;
  reg  [15:0] down_count_value;
  // Flags
  reg         wrap_flag;
  reg         zero_match_flag;
  reg         compare_match_flag;
  reg         evt_a_flag_ff;
  reg         evt_a_err_ff;
  reg         evt_b_flag_ff;
  reg         evt_b_err_ff;
  // Event history
  reg         evt_a_prev_ff;
  reg         evt_b_prev_ff;
  reg         run_prev_ff;

  wire        tick;
  wire        run_reset_ctl   = ctrl1_ff[`ART_C1_RUN];
  wire        reload_en       = ctrl1_ff[`ART_C1_RELOAD];
  wire        wrap_out_mode   = ctrl1_ff[`ART_C1_WRAP_MODE];
  wire [1:0]  prescale_sel    = {ctrl1_ff[`ART_C1_PSC_HI], ctrl1_ff[`ART_C1_PSC_LO]};
  wire [1:0]  start_src       = {ctrl2_ff[`ART_C2_SEL_HI], ctrl2_ff[`ART_C2_SEL_LO]};
  wire        pulse_out_enable   = pulse_ff[`ART_P_ENABLE];
  wire        pulse_out_mode     = pulse_ff[`ART_P_MODE];
  wire        pulse_out_polarity = pulse_ff[`ART_P_POL];

  // Active edge of a synchronous input with selectable polarity
  function edge_hit;
    input cur;
    input prev;
    input pol;
    begin
      edge_hit = pol ? (cur & ~prev) : (~cur & prev);
    end
  endfunction

  // Masked equality shared by both comparators
  function mask_eq;
    input [15:0] a;
    input [15:0] b;
    input [15:0] m;
    begin
      mask_eq = ((a & m) == (b & m));
    end
  endfunction

  art_prescaler u_psc (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .run_in     (run_reset_ctl),
    .sel_in     (prescale_sel),
    .tick_out   (tick)
  );

  // APB decode; write lands on the edge that sees pready high
  wire acc_phase = psel_in & penable_in;
  wire wr_now    = acc_phase & pready_out & pwrite_in;
  wire [7:0] wb  = pwdata_in[7:0];
  wire wr_c1     = wr_now && paddr_in == `ART_ADDR_CTRL1;
  wire wr_stat   = wr_now && paddr_in == `ART_ADDR_STATUS;

  // Event detection, enabled only while running
  wire a_edge = run_reset_ctl &
                edge_hit(event_in_a, evt_a_prev_ff, ctrl2_ff[`ART_C2_A_POL]);
  wire b_edge = run_reset_ctl &
                edge_hit(event_in_b, evt_b_prev_ff, ctrl2_ff[`ART_C2_B_POL]);
  wire sw_start = run_reset_ctl & ~run_prev_ff;

  // Capture is allowed only while the flag and error are both clear
  wire b_cap_ok = ~evt_b_flag_ff & ~evt_b_err_ff;
  wire a_cap_ok = ~evt_a_flag_ff & ~evt_a_err_ff;

  // Counter loads from preset on the selected start source
  reg  load_evt;
  always @*
  begin
    load_evt = 1'b0;
    if (reload_en)
    begin
      case (start_src)
        `ART_SRC_SW:    load_evt = sw_start;
        `ART_SRC_EVT_A: load_evt = a_edge;
        `ART_SRC_EVT_B: load_evt = b_edge;
        default:        load_evt = 1'b0;
      endcase
    end
  end

  // Capture strobes; reload mode never targets the preset register
  wire cap_b   = b_edge & b_cap_ok;
  wire cap_a   = a_edge & a_cap_ok & ~reload_en;
  wire at_zero = (down_count_value == `ART_CNT_ZERO);
  wire wrap_ev = run_reset_ctl & tick & at_zero & ~load_evt;

  // Next count value
  reg [15:0] nxt_count;
  always @*
  begin
    if (!run_reset_ctl)
      nxt_count = `ART_CNT_ZERO;
    else if (load_evt)
      nxt_count = preset_capture_reg;
    else if (tick && at_zero)
      nxt_count = reload_en ? preset_capture_reg
                            : `ART_CNT_FULL;
    else if (tick)
      nxt_count = down_count_value - 16'h0001;
    else
      nxt_count = down_count_value;
  end

  // Matches are judged on each new count value a tick or load gives; the clear when run drops is not judged
  wire cnt_upd  = run_reset_ctl & (tick | load_evt);
  wire zero_hit = cnt_upd & mask_eq(nxt_count, `ART_CNT_ZERO, mask_ff);
  wire cmp_hit  = cnt_upd & mask_eq(nxt_count, compare_reg, mask_ff);

  // Flag clears: wrap flag by writing zero, others write-one-to-clear
  wire clr_wrap = wr_c1 & ~wb[`ART_C1_WRAP_FLAG];
  wire clr_af   = wr_stat & wb[`ART_S_A_FLAG];
  wire clr_ae   = wr_stat & wb[`ART_S_A_ERR];
  wire clr_bf   = wr_stat & wb[`ART_S_B_FLAG];
  wire clr_be   = wr_stat & wb[`ART_S_B_ERR];
  wire clr_cmp  = wr_stat & wb[`ART_S_CMP];
  wire clr_zero = wr_stat & wb[`ART_S_ZERO];

  // Next flag values; a set in the clearing cycle wins
  wire nxt_wrap = (wrap_flag & ~clr_wrap) | wrap_ev;
  wire nxt_zero = (zero_match_flag & ~clr_zero) | zero_hit;
  wire nxt_cmpf = (compare_match_flag & ~clr_cmp) | cmp_hit;
  wire nxt_af   = (evt_a_flag_ff & ~clr_af) | (a_edge & ~evt_a_err_ff);
  wire nxt_ae   = (evt_a_err_ff & ~clr_ae) | (a_edge & evt_a_flag_ff);
  wire nxt_bf   = (evt_b_flag_ff & ~clr_bf) | (b_edge & ~evt_b_err_ff);
  wire nxt_be   = (evt_b_err_ff & ~clr_be) | (b_edge & evt_b_flag_ff);

  // Flags, counter and event history
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      down_count_value   <= `ART_CNT_ZERO;
      wrap_flag          <= 1'b0;
      zero_match_flag    <= 1'b0;
      compare_match_flag <= 1'b0;
      evt_a_flag_ff      <= 1'b0;
      evt_a_err_ff       <= 1'b0;
      evt_b_flag_ff      <= 1'b0;
      evt_b_err_ff       <= 1'b0;
      evt_a_prev_ff      <= 1'b0;
      evt_b_prev_ff      <= 1'b0;
      run_prev_ff        <= 1'b0;
    end
    else if (ce_in)
    begin
      down_count_value   <= nxt_count;
      wrap_flag          <= nxt_wrap;
      zero_match_flag    <= nxt_zero;
      compare_match_flag <= nxt_cmpf;
      evt_a_flag_ff      <= nxt_af;
      evt_a_err_ff       <= nxt_ae;
      evt_b_flag_ff      <= nxt_bf;
      evt_b_err_ff       <= nxt_be;
      evt_a_prev_ff      <= event_in_a;
      evt_b_prev_ff      <= event_in_b;
      run_prev_ff        <= run_reset_ctl;
    end
  end

  // Control registers; writes to flag bits are handled above
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ctrl1_ff <= `ART_BYTE_ZERO;
      ctrl2_ff <= `ART_BYTE_ZERO;
      pulse_ff <= `ART_BYTE_ZERO;
      inten_ff <= 5'h00;
    end
    else if (ce_in && wr_now)
    begin
      case (paddr_in)
        `ART_ADDR_CTRL1: ctrl1_ff <= wb & 8'hFA;
        `ART_ADDR_CTRL2: ctrl2_ff <= wb & 8'h0F;
        `ART_ADDR_PULSE: pulse_ff <= wb & 8'h07;
        `ART_ADDR_INTEN: inten_ff <= wb[4:0];
        default:         ctrl1_ff <= ctrl1_ff;
      endcase
    end
  end

  // 16-bit registers: high byte staged, both bytes land on low write
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      stage_ff           <= `ART_BYTE_ZERO;
      preset_capture_reg <= `ART_CNT_ZERO;
      compare_reg        <= `ART_CNT_ZERO;
      mask_ff            <= `ART_CNT_ZERO;
    end
    else if (ce_in)
    begin
      if (wr_now && (paddr_in == `ART_ADDR_PRESET_HI || paddr_in == `ART_ADDR_CMP_HI ||
                     paddr_in == `ART_ADDR_MASK_HI))
        stage_ff <= wb;
      if (cap_a)
        preset_capture_reg <= down_count_value;
      else if (wr_now && paddr_in == `ART_ADDR_PRESET_LO)
        preset_capture_reg <= {stage_ff, wb};
      if (wr_now && paddr_in == `ART_ADDR_CMP_LO)
        compare_reg <= {stage_ff, wb};
      if (wr_now && paddr_in == `ART_ADDR_MASK_LO)
        mask_ff <= {stage_ff, wb};
    end
  end

  // Capture register; reads the count before any same-cycle reload
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
      capture_reg <= `ART_CNT_ZERO;
    else if (ce_in && cap_b)
      capture_reg <= down_count_value;
  end

  // Output pins and interrupt, all registered
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      pulse_out_pin <= 1'b0;
      wrap_out_pin  <= 1'b0;
      irq_out       <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!pulse_out_enable)
        pulse_out_pin <= pulse_out_polarity;
      else if (pulse_out_mode)
      begin
        if (cmp_hit)
          pulse_out_pin <= ~pulse_out_pin;
      end
      else if (zero_hit)
        pulse_out_pin <= pulse_out_polarity;
      else if (cmp_hit)
        pulse_out_pin <= ~pulse_out_polarity;
      // Set mode follows the flag so a software clear also drops the pin
      if (wrap_out_mode)
      begin
        if (wrap_ev)
          wrap_out_pin <= ~wrap_out_pin;
      end
      else
        wrap_out_pin <= nxt_wrap;
      irq_out <= (nxt_af & inten_ff[`ART_I_A]) |
                 (nxt_bf & inten_ff[`ART_I_B]) |
                 (nxt_wrap & inten_ff[`ART_I_WRAP]) |
                 (nxt_cmpf & inten_ff[`ART_I_CMP]) |
                 (nxt_zero & inten_ff[`ART_I_ZERO]);
    end
  end

  // Read mux; unmapped addresses flag an error
  reg  [7:0] rd_byte;
  reg        rd_bad;
  always @*
  begin
    rd_bad = 1'b0;
    case (paddr_in)
      `ART_ADDR_CTRL1:     rd_byte = ctrl1_ff | {5'h00, wrap_flag, 2'h0};
      `ART_ADDR_CTRL2:     rd_byte = ctrl2_ff;
      `ART_ADDR_PULSE:     rd_byte = pulse_ff;
      `ART_ADDR_STATUS:    rd_byte = {2'h0, zero_match_flag, compare_match_flag,
                                      evt_b_err_ff, evt_b_flag_ff,
                                      evt_a_err_ff, evt_a_flag_ff};
      `ART_ADDR_INTEN:     rd_byte = {3'h0, inten_ff};
      `ART_ADDR_PRESET_HI: rd_byte = preset_capture_reg[15:8];
      `ART_ADDR_PRESET_LO: rd_byte = preset_capture_reg[7:0];
      `ART_ADDR_CMP_HI:    rd_byte = compare_reg[15:8];
      `ART_ADDR_CMP_LO:    rd_byte = compare_reg[7:0];
      `ART_ADDR_MASK_HI:   rd_byte = mask_ff[15:8];
      `ART_ADDR_MASK_LO:   rd_byte = mask_ff[7:0];
      `ART_ADDR_CAPT_HI:   rd_byte = capture_reg[15:8];
      `ART_ADDR_CAPT_LO:   rd_byte = capture_reg[7:0];
      `ART_ADDR_COUNT_HI:  rd_byte = down_count_value[15:8];
      `ART_ADDR_COUNT_LO:  rd_byte = down_count_value[7:0];
      default:
      begin
        rd_byte = `ART_BYTE_ZERO;
        rd_bad  = 1'b1;
      end
    endcase
  end

  // One wait state: answer registered from the first access cycle
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h00000000;
      pslverr_out <= 1'b0;
    end
    else if (ce_in)
    begin
      pready_out  <= acc_phase & ~pready_out;
      pslverr_out <= acc_phase & ~pready_out & rd_bad;
      if (acc_phase && !pready_out)
        prdata_out <= pwrite_in ? 32'h00000000 : {24'h000000, rd_byte};
    end
  end

endmodule // art_timer_core
`default_nettype wire

// file: verification/art_core_sva.sv
// Port-level assertions for the auto-reload timer core
`timescale 1ns/1ps
`default_nettype none

module art_core_sva (
  input wire logic        ref_clk_in,    // Clock
  input wire logic        rst_in,        // Sync reset
  input wire logic        ce_in,         // Clock enable
  input wire logic        psel_in,       // APB select
  input wire logic        penable_in,    // APB enable
  input wire logic [31:0] prdata_out,    // APB read data
  input wire logic        pready_out,    // APB ready
  input wire logic        pslverr_out,   // APB error
  input wire logic        pulse_out_pin, // Pulse pin
  input wire logic        wrap_out_pin,  // Wrap pin
  input wire logic        irq_out        // Interrupt
);
  // One clock domain, reset masks every check
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // Outputs idle once reset lets go
  AST_RST_PINS: assert property (
    $fell(rst_in) |-> !(pulse_out_pin | wrap_out_pin | irq_out | pready_out))
    else $error("outputs not idle after reset");
  // Bus answer lasts one cycle, after exactly one wait state
  AST_RDY_ONE: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  AST_RDY_WAIT: assert property (
    psel_in && penable_in && !pready_out && ce_in |=> pready_out)
    else $error("pready late");
  AST_RDY_CAUSE: assert property (
    $rose(pready_out) |-> $past(psel_in && penable_in))
    else $error("pready without access phase");
  AST_IDLE_NO_RDY: assert property (!psel_in && ce_in |=> !pready_out)
    else $error("pready while idle");
  // Refused transfers carry no data; upper read bits are zero
  AST_ERR_RDY: assert property (
    pslverr_out |-> pready_out && prdata_out == 32'h00000000)
    else $error("error answer malformed");
  AST_RD_HI: assert property (pready_out |-> prdata_out[31:8] == 24'h000000)
    else $error("upper read bits set");
  // Disabled clock freezes both pins, irq, pready and read data
  AST_FREEZE: assert property (
    !ce_in |=> $stable({pulse_out_pin, wrap_out_pin, irq_out, pready_out, prdata_out}))
    else $error("output moved while clock disabled");
endmodule // art_core_sva

bind art_timer_core art_core_sva art_core_sva_inst (.ref_clk_in, .rst_in, .ce_in, .psel_in,
  .penable_in, .prdata_out, .pready_out, .pslverr_out, .pulse_out_pin, .wrap_out_pin, .irq_out);
`default_nettype wire

// file: verification/art_evt_model.sv
// Far-side model: event line driver and output pin monitor
`timescale 1ns/1ps
`default_nettype none

module art_evt_model #(
  parameter int HOLD = 3                // Cycles an event line stays high
) (
  input  wire logic       ref_clk_in,    // Clock
  input  wire logic       rst_in,        // Sync reset
  input  wire logic [1:0] fire_in,       // Pulse request, bit 0 line a
  input  wire logic       pulse_out_pin, // Pulse pin of the block
  input  wire logic       wrap_out_pin,  // Wrap pin of the block
  output logic            event_in_a,    // Event line a
  output logic            event_in_b,    // Event line b
  output int              pulse_per_out, // Cycles between pulse rises
  output int              pulse_hi_out,  // Cycles pulse pin stayed high
  output int              wrap_per_out   // Cycles between wrap rises
);
  int         hold_a_ff, hold_b_ff, cnt_p_ff, cnt_w_ff;
  logic [1:0] pin_ff;

  // Lines idle low; a pulse gives one edge of each polarity
  assign event_in_a = (hold_a_ff != 0);
  assign event_in_b = (hold_b_ff != 0);

  // Lines move just after an edge, so sampling is never racy
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      hold_a_ff <= 0;
      hold_b_ff <= 0;
      pin_ff    <= 2'h0;
      cnt_p_ff  <= 0;
      cnt_w_ff  <= 0;
    end
    else
    begin
      hold_a_ff <= fire_in[0] ? HOLD : (hold_a_ff == 0 ? 0 : hold_a_ff - 1);
      hold_b_ff <= fire_in[1] ? HOLD : (hold_b_ff == 0 ? 0 : hold_b_ff - 1);
      pin_ff    <= {wrap_out_pin, pulse_out_pin};
      cnt_p_ff  <= (pulse_out_pin && !pin_ff[0]) ? 1 : cnt_p_ff + 1;
      cnt_w_ff  <= (wrap_out_pin && !pin_ff[1]) ? 1 : cnt_w_ff + 1;
      if (pulse_out_pin && !pin_ff[0])
        pulse_per_out <= cnt_p_ff;
      if (!pulse_out_pin && pin_ff[0])
        pulse_hi_out <= cnt_p_ff;
      if (wrap_out_pin && !pin_ff[1])
        wrap_per_out <= cnt_w_ff;
    end
  end
endmodule // art_evt_model
`default_nettype wire

// file: verification/testbench.sv
// Self-checking testbench for the auto-reload timer core
`timescale 1ns/1ps
`default_nettype none
`include "art_defines.vh"

module testbench;
  logic        ref_clk_in, rst_in, ce_in, psel_in, penable_in, pwrite_in, rerr;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, rdata;
  logic [1:0]  fire_in;
  wire  [31:0] prdata_out;
  wire         pready_out, pslverr_out, pulse_out_pin, wrap_out_pin, irq_out;
  wire         event_in_a, event_in_b;
  int          pulse_per_out, pulse_hi_out, wrap_per_out, err_total, n_compared;

  art_timer_core art_timer_core_inst (.ref_clk_in, .rst_in, .ce_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .event_in_a,
    .event_in_b, .pulse_out_pin, .wrap_out_pin, .irq_out);
  art_evt_model art_evt_model_inst (.ref_clk_in, .rst_in, .fire_in, .pulse_out_pin,
    .wrap_out_pin, .event_in_a, .event_in_b, .pulse_per_out, .pulse_hi_out, .wrap_per_out);

  // 40 ns clock
  always #20 ref_clk_in = ~ref_clk_in;

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask

  // One APB transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    // No cycle count assumed; the hang guard ends a dead bus
    do
    begin
      @(posedge ref_clk_in);
    end
    while (pready_out !== 1'b1);
    rdata = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  // High byte staged first, low byte commits
  task automatic w16(input logic [7:0] a, input logic [15:0] d);
    w(a, d[15:8]);
    w(a + 8'h04, d[7:0]);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rdata & m, e);
  endtask

  task automatic fire(input logic [1:0] m);
    fire_in <= m;
    tick(1);
    fire_in <= 2'h0;
    tick(6);
  endtask

  task automatic test_regs;
    rchk(`ART_ADDR_CTRL1, 32'hFF, 32'h00);
    w16(`ART_ADDR_PRESET_HI, 16'h1234);
    rchk(`ART_ADDR_PRESET_LO, 32'hFF, 32'h34);
    w(`ART_ADDR_PRESET_HI, 8'h56);
    rchk(`ART_ADDR_PRESET_HI, 32'hFF, 32'h12);
    w(`ART_ADDR_PRESET_LO, 8'h78);
    rchk(`ART_ADDR_PRESET_HI, 32'hFF, 32'h56);
    apb(1'b0, 8'hFC, 32'h00000000);
    chk({31'h0, rerr}, 32'h1);
    w(`ART_ADDR_CTRL1, 8'h60);
    tick(20);
    rchk(`ART_ADDR_COUNT_LO, 32'hFF, 32'h00);
    $display("registers test done");
  endtask

  task automatic test_free;
    logic [31:0] v;
    w(`ART_ADDR_CTRL2, 8'h0C);
    w(`ART_ADDR_CTRL1, 8'h50);
    tick(20);
    fire(2'h1);
    rchk(`ART_ADDR_PRESET_HI, 32'hFF, 32'hFF);
    rchk(`ART_ADDR_STATUS, 32'h0F, 32'h01);
    // Event b now on its falling edge, a stays rising
    w(`ART_ADDR_CTRL2, 8'h04);
    fire(2'h2);
    rchk(`ART_ADDR_CAPT_HI, 32'hFF, 32'hFF);
    rchk(`ART_ADDR_STATUS, 32'h0F, 32'h05);
    apb(1'b0, `ART_ADDR_PRESET_LO, 32'h00000000);
    v = rdata;
    fire(2'h1);
    rchk(`ART_ADDR_STATUS, 32'h0F, 32'h07);
    rchk(`ART_ADDR_PRESET_LO, 32'hFF, v);
    $display("free-run capture test done");
  endtask

  task automatic test_restart;
    logic [1:0] s;
    logic [31:0] v;
    w16(`ART_ADDR_PRESET_HI, 16'h1234);
    // Event a, then event b restart; count far from preset beforehand
    for (s = 2'h1; s != 2'h3; s++)
    begin
      w(`ART_ADDR_CTRL1, 8'h00);
      w(`ART_ADDR_STATUS, 8'h3F);
      w(`ART_ADDR_CTRL2, {6'h03, s});
      w(`ART_ADDR_CTRL1, 8'h70);
      tick(2500);
      fire(s);
      rchk(`ART_ADDR_COUNT_HI, 32'hFF, 32'h12);
      if (s == 2'h1)
      begin
        fire(2'h2);
        rchk(`ART_ADDR_CAPT_HI, 32'hFF, 32'h12);
        rchk(`ART_ADDR_PRESET_LO, 32'hFF, 32'h34);
      end
    end
    w(`ART_ADDR_CTRL2, 8'h0C);
    w(`ART_ADDR_CTRL1, 8'h60);
    rchk(`ART_ADDR_COUNT_HI, 32'hFF, 32'h00);
    w(`ART_ADDR_CTRL1, 8'h70);
    rchk(`ART_ADDR_COUNT_HI, 32'hFF, 32'h12);
    // Prescale off with run still set: count must hold
    w(`ART_ADDR_CTRL1, 8'h30);
    apb(1'b0, `ART_ADDR_COUNT_LO, 32'h00000000);
    v = rdata;
    tick(40);
    rchk(`ART_ADDR_COUNT_LO, 32'hFF, v);
    $display("restart test done");
  endtask

  task automatic test_pulse;
    logic [1:0] p;
    int psc;
    w16(`ART_ADDR_PRESET_HI, 16'h0005);
    w16(`ART_ADDR_MASK_HI, 16'hFFFF);
    w16(`ART_ADDR_CMP_HI, 16'h0002);
    // Every prescale ratio; prescaler stopped before each change
    for (p = 2'h1; p != 2'h0; p++)
    begin
      psc = 1 << (2 * (p - 1));
      w(`ART_ADDR_CTRL1, 8'h00);
      w(`ART_ADDR_PULSE, 8'h05);
      w(`ART_ADDR_CTRL1, {p, 6'h32});
      tick(500);
      chk(pulse_per_out, 6 * psc);
      chk(pulse_hi_out, 4 * psc);
      chk(wrap_per_out, 12 * psc);
    end
    w(`ART_ADDR_PULSE, 8'h01);
    tick(300);
    chk(pulse_hi_out, 2 * psc);
    w(`ART_ADDR_PULSE, 8'h03);
    tick(600);
    chk(pulse_per_out, 12 * psc);
    chk(pulse_hi_out, 6 * psc);
    ce_in <= 1'b0;
    tick(10);
    ce_in <= 1'b1;
    w(`ART_ADDR_PULSE, 8'h04);
    tick(4);
    chk({31'h0, pulse_out_pin}, 32'h1);
    w(`ART_ADDR_PULSE, 8'h00);
    tick(4);
    chk({31'h0, pulse_out_pin}, 32'h0);
    w(`ART_ADDR_CTRL1, 8'h00);
    w16(`ART_ADDR_MASK_HI, 16'h0003);
    w(`ART_ADDR_PULSE, 8'h05);
    w(`ART_ADDR_CTRL1, 8'h50);
    tick(100);
    chk(pulse_per_out, 4);
    chk(pulse_hi_out, 2);
    rchk(`ART_ADDR_STATUS, 32'h30, 32'h30);
    w16(`ART_ADDR_MASK_HI, 16'h0000);
    w(`ART_ADDR_PULSE, 8'h03);
    tick(100);
    chk(pulse_per_out, 2);
    $display("pulse test done");
  endtask

  task automatic test_wrap;
    int n;
    w(`ART_ADDR_CTRL1, 8'h00);
    w16(`ART_ADDR_PRESET_HI, 16'h01FF);
    w(`ART_ADDR_INTEN, 8'h04);
    w(`ART_ADDR_CTRL1, 8'h70);
    n = 0;
    while (wrap_out_pin !== 1'b1 && n < 2000)
    begin
      tick(1);
      n++;
    end
    chk({31'h0, wrap_out_pin}, 32'h1);
    tick(2);
    chk({31'h0, irq_out}, 32'h1);
    rchk(`ART_ADDR_CTRL1, 32'h04, 32'h04);
    w(`ART_ADDR_INTEN, 8'h00);
    tick(2);
    chk({31'h0, irq_out}, 32'h0);
    chk({31'h0, wrap_out_pin}, 32'h1);
    w(`ART_ADDR_CTRL1, 8'h70);
    tick(3);
    chk({31'h0, wrap_out_pin}, 32'h0);
    $display("wrap test done");
  endtask

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    ref_clk_in = 1'b0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h00000000;
    fire_in = 2'h0;
    err_total = 0;
    n_compared = 0;
    tick(3);
    rst_in <= 1'b0;
    test_regs;
    test_free;
    test_restart;
    test_pulse;
    test_wrap;
    end_sim;
  end

  // Hang guard, nearly five times the expected run
  initial
  begin
    tick(40000);
    err_total++;
    end_sim;
  end
endmodule // testbench
`default_nettype wire
